// ===== dv/clw_cache_lru_props.sv
`timescale 1ns/100ps
module clw_cache_lru_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic op_valid,
   input wire logic op_ready,
   input wire logic rsp_valid,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic ivn_valid,
   input wire logic ivn_ready,
   input wire logic ivn_rsp_valid,
   input wire logic ivn_rsp_hit,
   input wire logic ivn_rsp_dirty
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   //////////////////////////////
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access with data");
   a_op_taken: assert property (op_valid && op_ready |=> !op_ready)
      else $error("ready kept after take");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   a_busy_mem: assert property (mem_req |-> !op_ready)
      else $error("memory beat while idle");
   a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req &&
      $stable(mem_addr) && $stable(mem_we))
      else $error("beat changed before ack");
   a_beat_gap: assert property (mem_req && mem_ack |=> !mem_req)
      else $error("no gap after beat");
   a_ivn_answer: assert property (ivn_valid && ivn_ready |=> ivn_rsp_valid)
      else $error("intervention not answered");
   a_ivn_dirty: assert property (ivn_rsp_valid && ivn_rsp_dirty |-> ivn_rsp_hit)
      else $error("dirty reported on miss");
endmodule // clw_cache_lru_props
bind clw_cache_lru clw_cache_lru_props i_clw_cache_lru_props (.clk, .nrst,
   .psel, .penable, .prdata, .pready, .pslverr, .op_valid, .op_ready,
   .rsp_valid, .mem_req, .mem_we, .mem_addr, .mem_ack, .ivn_valid,
   .ivn_ready, .ivn_rsp_valid, .ivn_rsp_hit, .ivn_rsp_dirty);

// ===== dv/clw_cache_lru_tb.sv
`timescale 1ns/100ps
module clw_cache_lru_tb;
   import clw_pkg::*;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, op_addr, op_wdata, rsp_data;
   logic op_valid, op_ready, op_store, rsp_valid, rsp_hit;
   clw_op_t op_kind;
   logic [1:0] op_way, rsp_way;
   logic [0:0] op_thread;
   logic mem_req, mem_we, mem_ack, ivn_valid, ivn_ready, ivn_excl, ivn_self;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, wb_a, wb_d, ivn_addr;
   logic ivn_rsp_valid, ivn_rsp_hit, ivn_rsp_dirty;
   int err_count, tests_run, wr_n, rd_n, last_w_rd, w0, r0;
   clw_cache_lru i_clw_cache_lru (.clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_ready,
      .op_kind, .op_addr, .op_way, .op_thread, .op_store, .op_wdata,
      .rsp_valid, .rsp_hit, .rsp_way, .rsp_data, .mem_req, .mem_we,
      .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ivn_valid, .ivn_ready,
      .ivn_addr, .ivn_excl, .ivn_self, .ivn_rsp_valid, .ivn_rsp_hit,
      .ivn_rsp_dirty);
   clw_mem_model i_clw_mem_model (.clk, .nrst, .mem_req, .mem_addr,
      .mem_ack, .mem_rdata);
   //////////////////////////////
   always @(posedge clk) begin
      if (nrst && mem_req && mem_ack && mem_we) begin
         wr_n++;
         last_w_rd = rd_n;
         if (mem_addr[4:0] == 5'h00) begin
            wb_a = mem_addr;
            wb_d = mem_wdata;
         end
      end else if (nrst && mem_req && mem_ack) rd_n++;
   end
   task test_done;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         $display("CHECK FAILED t=%0t %s", $time, m);
         err_count++;
      end
   endtask
   function logic sig(input int w);
      case (w)
         0: return pready;
         1: return op_ready;
         2: return rsp_valid;
         3: return ivn_ready;
         default: return ivn_rsp_valid;
      endcase
   endfunction
   task wait_hi(input int w);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sig(w) !== 1'b1 && n < 400);
      if (sig(w) !== 1'b1) begin
         $display("CHECK FAILED t=%0t timeout", $time);
         err_count++;
         test_done;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      wait_hi(0);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task op(input clw_op_t k, input int t, input logic s);
      w0 = wr_n;
      r0 = rd_n;
      @(posedge clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_addr <= 32'(t) << 12;
      op_store <= s;
      wait_hi(1);
      op_valid <= 1'b0;
      wait_hi(2);
   endtask
   task miss(input int t, input logic [1:0] e);
      op(CO_LOOKUP, t, 1'b0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rsp_hit === 1'b1 && rsp_way === e && rd[2:1] === e, "victim way");
      chk(rd_n - r0 == 8, "fill beats");
      chk(rsp_data === ((32'(t) << 12) ^ 32'h5a5a_0000),
         "fill data");
   endtask
   task ivn(input int t, input logic s, input logic e);
      @(posedge clk);
      ivn_valid <= 1'b1;
      ivn_addr <= 32'(t) << 12;
      ivn_self <= s;
      wait_hi(3);
      ivn_valid <= 1'b0;
      wait_hi(4);
      chk(ivn_rsp_hit === e && ivn_rsp_dirty === 1'b0, "intervention hit");
   endtask
   //////////////////////////////
   task s_regs;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd === REG_RST && perr === 1'b0, "reset value");
      end
      apb(1'b1, OFS_ECR, 32'hffff_ffff);
      apb(1'b0, OFS_ECR, 32'h0);
      chk(rd === ECR_MASK, "control bits");
      apb(1'b1, OFS_ECR, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk(perr === 1'b1 && rd === 32'h0, "unmapped");
   endtask
   task s_fill;
      for (int t = 1; t < 5; t++) miss(t, 2'(t - 1));
   endtask
   task s_lru;
      op(CO_LOOKUP, 1, 1'b1);
      chk(rsp_hit === 1'b1 && rsp_way === 2'h0, "store hit");
      chk(rsp_data === 32'h5a5a_1000, "hit data");
      miss(5, 2'h1);
      chk(wr_n == w0 && rd_n - r0 == 8, "clean fill");
   endtask
   task s_lock;
      op(CO_FETCH_LOCK, 3, 1'b0);
      miss(6, 2'h3);
   endtask
   task s_wb;
      miss(7, 2'h0);
      chk(wr_n - w0 == 8 && last_w_rd == r0, "writeback first");
      chk(wb_a === 32'h0000_1000 && rd_n - r0 == 8, "victim line");
      chk(wb_d === 32'hc0de_0001, "victim data");
   endtask
   task s_ivn;
      ivn(3, 1'b0, 1'b0);
      ivn(3, 1'b1, 1'b1);
   endtask
   task s_wst;
      apb(1'b1, OFS_ECR, 32'h8000_0000);
      apb(1'b1, OFS_TAG, 32'h0000_0022);
      op(CO_IDX_ST_TAG, 0, 1'b0);
      apb(1'b1, OFS_ECR, 32'h0);
      miss(8, 2'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {nrst, psel, penable, pwrite, op_valid, op_store, ivn_valid} = '0;
      {ivn_excl, ivn_self, paddr, pwdata, op_addr, op_way} = '0;
      {ivn_addr, op_thread, err_count, tests_run} = '0;
      op_kind = CO_LOOKUP;
      op_wdata = 32'hc0de_0001;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      s_regs;
      s_fill;
      s_lru;
      s_lock;
      s_wb;
      s_ivn;
      s_wst;
      test_done;
   end
endmodule // clw_cache_lru_tb

// ===== dv/clw_mem_model.sv
`timescale 1ns/100ps
module clw_mem_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [1:0] wait_cnt;
   // odd words answer slowly, even words at once
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_cnt <= 2'h0;
         mem_ack <= 1'b0;
      end else if (mem_req && !mem_ack) begin
         wait_cnt <= wait_cnt + 2'h1;
         mem_ack <= !mem_addr[2] || wait_cnt == 2'h2;
      end else begin
         wait_cnt <= 2'h0;
         mem_ack <= 1'b0;
      end
   end
   // data only meaningful with ack
   assign mem_rdata = mem_ack ? mem_addr ^ 32'h5a5a_0000 : ~mem_addr;
endmodule // clw_mem_model

// ===== rtl/clw_cache_lru.sv
`timescale 1ns/100ps
// How it works
// RQ1 - miss fill way by LRU, locked only if invalid or every way is locked or excluded
// RQ2 - hit way becomes MRU, others keep order
// RQ3 - refill or fill op makes way MRU
// RQ4 - index invalidate makes LRU; others untouched
// RQ5 - tag write: valid gives MRU, else LRU
// RQ6 - test tag write loads way order directly
// RQ7 - hit invalidate makes LRU only on hit
// RQ8 - fetch-lock: icache no update, dcache MRU
// RQ9 - full set: LRU among unlocked ways
// RQ10 - dirty victim written back before fill
// RQ11 - lock by fetch-lock or tag write
// RQ12 - per-thread excluded ways never victims; code takes one when it is invalid or when every way is locked or excluded
// RQ13 - icache sync never clears a lock
// RQ14 - foreign interventions miss locked lines
// RQ15 - all locked: displace one anyway
// RQ16 - tag ops pick array by test bits
// RQ17 - six-bit way order, 24 legal codes
// RQ18 - both test bits reach duplicate tags
// RQ19 - parity override stores staged parity
// RQ20 - icache data write needs test bit
// RQ21 - dcache data test: 32b, byte parity
// RQ22 - four coherence states per line
// RQ23 - tag entry has valid and lock bits
// RQ24 - way-select entry holds dirty bits
// RQ25 - invalid way filled before eviction
module clw_cache_lru #(
   parameter int INDEX_W = 7,
   parameter int TH_W = 1,
   parameter bit IS_ICACHE = 1'b0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   output logic op_ready,
   input wire clw_pkg::clw_op_t op_kind,
   input wire logic [31:0] op_addr,
   input wire logic [1:0] op_way,
   input wire logic [TH_W-1:0] op_thread,
   input wire logic op_store,
   input wire logic [31:0] op_wdata,
   output logic rsp_valid,
   output logic rsp_hit,
   output logic [1:0] rsp_way,
   output logic [31:0] rsp_data,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic ivn_valid,
   output logic ivn_ready,
   input wire logic [31:0] ivn_addr,
   input wire logic ivn_excl,
   input wire logic ivn_self,
   output logic ivn_rsp_valid,
   output logic ivn_rsp_hit,
   output logic ivn_rsp_dirty
);
   import clw_pkg::*;
   localparam int SETS = 1 << INDEX_W;
   localparam int TAG_W = 32 - INDEX_W - OFF_W;
   localparam int EXW = WAYS << TH_W;

   typedef enum {S_IDLE, S_EXEC, S_WBK, S_FIL, S_FIN} clw_state_t;

   clw_state_t st;
   logic [TAG_W-1:0] tag_a [SETS][WAYS];
   logic [TAG_W-1:0] dup_a [SETS][WAYS];
   clw_mesi_t mesi_a [SETS][WAYS];
   logic [WAYS-1:0] val_a [SETS];
   logic [WAYS-1:0] lck_a [SETS];
   logic [WAYS-1:0] par_a [SETS];
   logic [WAYS-1:0] drt_a [SETS];
   logic [5:0] ord_a [SETS];
   logic [31:0] dat_a [SETS][WAYS][8];
   logic [3:0] dpar_a [SETS][WAYS][8];
   logic [PCW-1:0] pcode_a [SETS][WAYS][8];
   logic [31:0] spr_pt [WAYS];
   logic [31:0] itc_pt [WAYS];
   logic [31:0] ecr;
   logic [31:0] tag_stg;
   logic [31:0] dlo;
   logic [31:0] dhi;
   logic [EXW-1:0] excl;
   clw_op_t ck;
   logic [INDEX_W-1:0] ci;
   logic [TAG_W-1:0] ct;
   logic [BEAT_W-1:0] cb;
   logic [BEAT_W-1:0] beat;
   logic [1:0] cw;
   logic [TH_W-1:0] cth;
   logic cst;
   logic [31:0] cwd;
   logic then_fill;
   logic [1:0] last_vic;
   logic [WAYS-1:0] hv;
   logic [1:0] hw;
   logic [WAYS-1:0] cand;
   logic [1:0] vic;
   logic [WAYS-1:0] im;
   logic [1:0] iw;
   logic [INDEX_W-1:0] ii;
   logic [TAG_W-1:0] itg;
   logic apb_wr;
   logic [TAG_W-1:0] stg_tag;
   logic stg_par;

   assign apb_wr = psel & penable & pwrite & pready;
   assign ii = ivn_addr[OFF_W +: INDEX_W];
   assign itg = ivn_addr[31 -: TAG_W];
   assign stg_tag = tag_stg[TG_TAG +: TAG_W];
   // parity override stores the staged bit
   assign stg_par = ecr[ECR_PO] ? tag_stg[TG_P] : ^stg_tag; // see RQ19

   ////////////////////////////////////////////////////////////////////////
   // lookup match, victim choice, intervention match
   always_comb begin
      hv = '0;
      hw = 2'h0;
      im = '0;
      iw = 2'h0;
      for (int w = 0; w < WAYS; w++) begin
         hv[w] = val_a[ci][w] && tag_a[ci][w] == ct;
         if (hv[w]) hw = 2'(w);
         // locked lines miss unless self-intervention
         im[w] = val_a[ii][w] && tag_a[ii][w] == itg
            && (!lck_a[ii][w] || ivn_self); // see RQ14
         if (im[w]) iw = 2'(w);
      end
      cand = ~lck_a[ci] & ~excl[4*cth +: 4]; // see RQ9 see RQ12
      if (cand == '0) cand = '1; // see RQ15
      vic = clw_lru(ord_a[ci], cand); // see RQ1 see RQ17
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (!val_a[ci][w]) vic = 2'(w); // see RQ25
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: no wait states, exclusion masks, read mux
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= REG_RST;
         excl <= '0;
      end else begin
         pready <= psel & ~penable & ~pready;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            prdata <= REG_RST;
            case (paddr)
               OFS_ECR: prdata <= ecr;
               OFS_TAG: prdata <= tag_stg;
               OFS_DLO: prdata <= dlo;
               OFS_DHI: prdata <= dhi;
               OFS_EXCL: prdata <= 32'(excl);
               OFS_STAT: prdata <= {29'h0, last_vic, st != S_IDLE};
               default: pslverr <= 1'b1;
            endcase
         end
         if (apb_wr && paddr == OFS_EXCL) excl <= pwdata[EXW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer, staging registers and cache arrays
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= S_IDLE;
         op_ready <= 1'b0;
         ivn_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_hit <= 1'b0;
         rsp_way <= 2'h0;
         rsp_data <= REG_RST;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= REG_RST;
         mem_wdata <= REG_RST;
         ivn_rsp_valid <= 1'b0;
         ivn_rsp_hit <= 1'b0;
         ivn_rsp_dirty <= 1'b0;
         ecr <= REG_RST;
         tag_stg <= REG_RST;
         dlo <= REG_RST;
         dhi <= REG_RST;
         ck <= CO_LOOKUP;
         ci <= '0;
         ct <= '0;
         cb <= '0;
         beat <= '0;
         cw <= 2'h0;
         cth <= '0;
         cst <= 1'b0;
         cwd <= REG_RST;
         then_fill <= 1'b0;
         last_vic <= 2'h0;
         for (int w = 0; w < WAYS; w++) begin
            spr_pt[w] <= REG_RST;
            itc_pt[w] <= REG_RST;
         end
         for (int s = 0; s < SETS; s++) begin
            val_a[s] <= '0;
            lck_a[s] <= '0;
            par_a[s] <= '0;
            drt_a[s] <= '0;
            ord_a[s] <= ORD_RST;
            for (int w = 0; w < WAYS; w++) begin
               tag_a[s][w] <= '0;
               dup_a[s][w] <= '0;
               mesi_a[s][w] <= ST_INV;
               for (int b = 0; b < 8; b++) begin
                  dat_a[s][w][b] <= REG_RST;
                  dpar_a[s][w][b] <= 4'h0;
                  pcode_a[s][w][b] <= '0;
               end
            end
         end
      end else begin
         rsp_valid <= 1'b0;
         ivn_rsp_valid <= 1'b0;
         if (apb_wr) begin
            case (paddr)
               OFS_ECR: ecr <= pwdata & ECR_MASK;
               OFS_TAG: tag_stg <= pwdata;
               OFS_DLO: dlo <= pwdata;
               OFS_DHI: dhi <= pwdata;
               default: ;
            endcase
         end
         case (st)
            S_IDLE: begin
               op_ready <= 1'b1;
               ivn_ready <= 1'b1;
               if (ivn_valid && ivn_ready) begin
                  ivn_rsp_valid <= 1'b1;
                  ivn_rsp_hit <= |im;
                  ivn_rsp_dirty <= |(im & drt_a[ii]);
                  if (|im && ivn_excl) begin
                     val_a[ii][iw] <= 1'b0;
                     drt_a[ii][iw] <= 1'b0;
                     mesi_a[ii][iw] <= ST_INV; // see RQ22
                  end else if (|im) begin
                     drt_a[ii][iw] <= 1'b0;
                     mesi_a[ii][iw] <= ST_SHR; // see RQ22
                  end
               end
               if (op_valid && op_ready) begin
                  op_ready <= 1'b0;
                  ivn_ready <= 1'b0;
                  ck <= op_kind;
                  ci <= op_addr[OFF_W +: INDEX_W];
                  ct <= op_addr[31 -: TAG_W];
                  cb <= op_addr[2 +: BEAT_W];
                  cw <= op_way;
                  cth <= op_thread;
                  cst <= op_store;
                  cwd <= op_wdata;
                  st <= S_EXEC;
               end
            end
            S_EXEC: begin
               st <= S_IDLE;
               rsp_valid <= 1'b1;
               rsp_hit <= |hv;
               rsp_way <= hw;
               beat <= '0;
               case (ck)
                  CO_LOOKUP, CO_FILL, CO_FETCH_LOCK: begin
                     if (|hv) begin
                        if (ck != CO_FETCH_LOCK || !IS_ICACHE) begin
                           ord_a[ci] <= clw_place(ord_a[ci], hw,
                              1'b1); // see RQ2 see RQ8
                        end
                        if (ck == CO_FETCH_LOCK) begin
                           lck_a[ci][hw] <= 1'b1; // see RQ11
                        end
                        rsp_data <= dat_a[ci][hw][cb];
                        if (ck == CO_LOOKUP && cst) begin
                           dat_a[ci][hw][cb] <= cwd;
                           drt_a[ci][hw] <= 1'b1; // see RQ24
                           mesi_a[ci][hw] <= ST_MOD;
                        end
                     end else begin
                        rsp_valid <= 1'b0;
                        cw <= vic;
                        last_vic <= vic;
                        then_fill <= 1'b1;
                        // dirty victim goes out first
                        st <= (val_a[ci][vic] && drt_a[ci][vic])
                           ? S_WBK : S_FIL; // see RQ10
                     end
                  end
                  CO_IDX_INV, CO_IDX_WB_INV: begin
                     rsp_valid <= 1'b0;
                     then_fill <= 1'b0;
                     st <= (ck == CO_IDX_WB_INV && val_a[ci][cw]
                        && drt_a[ci][cw]) ? S_WBK : S_FIN;
                  end
                  CO_HIT_INV, CO_HIT_WB_INV, CO_HIT_WB, CO_ICACHE_SYNC_OP: begin
                     then_fill <= 1'b0;
                     cw <= hw;
                     // a locked line is left alone by icache sync
                     if (|hv && !(ck == CO_ICACHE_SYNC_OP && lck_a[ci][hw])) begin
                        rsp_valid <= 1'b0;
                        st <= (ck != CO_HIT_INV && drt_a[ci][hw])
                           ? S_WBK : S_FIN; // see RQ13
                     end
                  end
                  CO_IDX_LD_TAG: begin
                     // array picked by test bits
                     if (ecr[ECR_WST] && ecr[ECR_SPR]) begin
                        tag_stg <= REG_RST;
                        tag_stg[TG_TAG +: TAG_W] <= dup_a[ci][cw]; // see RQ18
                     end else if (ecr[ECR_WST]) begin
                        tag_stg <= {20'h0, drt_a[ci], 2'h0,
                           ord_a[ci]}; // see RQ16
                     end else if (ecr[ECR_SPR]) begin
                        tag_stg <= spr_pt[cw]; // see RQ16
                     end else if (ecr[ECR_ITC]) begin
                        tag_stg <= itc_pt[cw]; // see RQ16
                     end else begin
                        tag_stg <= REG_RST;
                        tag_stg[TG_TAG +: TAG_W] <= tag_a[ci][cw];
                        tag_stg[TG_ST +: 2] <= mesi_a[ci][cw];
                        tag_stg[TG_V] <= val_a[ci][cw];
                        tag_stg[TG_L] <= lck_a[ci][cw];
                        tag_stg[TG_P] <= par_a[ci][cw];
                     end
                  end
                  CO_IDX_ST_TAG: begin
                     if (ecr[ECR_WST] && ecr[ECR_SPR]) begin
                        dup_a[ci][cw] <= stg_tag; // see RQ18
                     end else if (ecr[ECR_WST]) begin
                        ord_a[ci] <= tag_stg[TG_WS +: 6]; // see RQ6
                        drt_a[ci] <= tag_stg[TG_D +: 4]; // see RQ24
                     end else if (ecr[ECR_SPR]) begin
                        spr_pt[cw] <= tag_stg; // see RQ16
                     end else if (ecr[ECR_ITC]) begin
                        itc_pt[cw] <= tag_stg; // see RQ16
                     end else begin
                        tag_a[ci][cw] <= stg_tag; // see RQ23
                        dup_a[ci][cw] <= stg_tag; // see RQ18
                        val_a[ci][cw] <= tag_stg[TG_V];
                        lck_a[ci][cw] <= tag_stg[TG_L]; // see RQ11
                        par_a[ci][cw] <= stg_par;
                        mesi_a[ci][cw] <= clw_mesi_t'(tag_stg[TG_ST +: 2]);
                        ord_a[ci] <= clw_place(ord_a[ci], cw,
                           tag_stg[TG_V]); // see RQ5
                     end
                  end
                  CO_IDX_LD_DATA: begin
                     dlo <= dat_a[ci][cw][cb];
                     if (IS_ICACHE) begin
                        dhi <= {26'h0, pcode_a[ci][cw][cb],
                           dpar_a[ci][cw][cb]};
                     end else begin
                        ecr[ECR_PD +: 4] <= dpar_a[ci][cw][cb]; // see RQ21
                     end
                  end
                  CO_IDX_ST_DATA: begin
                     if (!IS_ICACHE || ecr[ECR_WST]) begin // see RQ20
                        dat_a[ci][cw][cb] <= dlo; // see RQ21
                        dpar_a[ci][cw][cb] <= !ecr[ECR_PO] ? bpar(dlo)
                           : IS_ICACHE ? ecr[ECR_PI +: 4]
                           : ecr[ECR_PD +: 4];
                        pcode_a[ci][cw][cb] <= ecr[ECR_PCO]
                           ? ecr[ECR_PCI +: PCW]
                           : dlo[31 -: PCW]; // see RQ20
                     end
                  end
                  default: ;
               endcase
            end
            S_WBK: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= {tag_a[ci][cw], ci, beat, 2'h0};
                  mem_wdata <= dat_a[ci][cw][beat];
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  beat <= beat + BEAT_W'(1);
                  if (beat == LAST_BEAT) begin
                     drt_a[ci][cw] <= 1'b0; // see RQ10
                     st <= then_fill ? S_FIL : S_FIN;
                  end
               end
            end
            S_FIL: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= {ct, ci, beat, 2'h0};
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  beat <= beat + BEAT_W'(1);
                  dat_a[ci][cw][beat] <= mem_rdata;
                  dpar_a[ci][cw][beat] <= bpar(mem_rdata);
                  pcode_a[ci][cw][beat] <= mem_rdata[31 -: PCW];
                  if (beat == LAST_BEAT) begin
                     tag_a[ci][cw] <= ct;
                     dup_a[ci][cw] <= ct;
                     par_a[ci][cw] <= ^ct;
                     val_a[ci][cw] <= 1'b1;
                     drt_a[ci][cw] <= 1'b0;
                     lck_a[ci][cw] <= ck == CO_FETCH_LOCK; // see RQ11
                     mesi_a[ci][cw] <= cst ? ST_EXC : ST_SHR;
                     ord_a[ci] <= clw_place(ord_a[ci], cw,
                        1'b1); // see RQ3
                     st <= S_EXEC;
                  end
               end
            end
            S_FIN: begin
               st <= S_IDLE;
               rsp_valid <= 1'b1;
               if (ck != CO_HIT_WB) begin
                  val_a[ci][cw] <= 1'b0;
                  drt_a[ci][cw] <= 1'b0;
                  mesi_a[ci][cw] <= ST_INV;
                  if (ck != CO_ICACHE_SYNC_OP) lck_a[ci][cw] <= 1'b0;
                  if (ck != CO_ICACHE_SYNC_OP) begin
                     ord_a[ci] <= clw_place(ord_a[ci], cw,
                        1'b0); // see RQ4 see RQ7
                  end
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   function automatic logic [3:0] bpar(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction
endmodule // clw_cache_lru

// ===== shared/clw_pkg.sv
package clw_pkg;
   localparam int WAYS = 4;
   localparam int OFF_W = 5;
   localparam int LINE_BYTES = 32;
   localparam int BEAT_W = 3;
   localparam int PCW = 2;
   localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;
   localparam logic [11:0] OFS_ECR = 12'h000;
   localparam logic [11:0] OFS_TAG = 12'h004;
   localparam logic [11:0] OFS_DLO = 12'h008;
   localparam logic [11:0] OFS_DHI = 12'h00c;
   localparam logic [11:0] OFS_EXCL = 12'h010;
   localparam logic [11:0] OFS_STAT = 12'h014;
   localparam int ECR_WST = 31;
   localparam int ECR_PO = 30;
   localparam int ECR_SPR = 28;
   localparam int ECR_PCO = 27;
   localparam int ECR_ITC = 26;
   localparam int ECR_PI = 12;
   localparam int ECR_PCI = 8;
   localparam int ECR_PD = 4;
   localparam logic [31:0] ECR_MASK = 32'hdc00_f3f0;
   localparam int TG_TAG = 12;
   localparam int TG_ST = 6;
   localparam int TG_V = 5;
   localparam int TG_L = 4;
   localparam int TG_P = 0;
   localparam int TG_WS = 0;
   localparam int TG_D = 8;
   localparam logic [5:0] ORD_RST = 6'h00;
   localparam logic [31:0] REG_RST = 32'h0000_0000;

   typedef enum logic [3:0] {
      CO_LOOKUP, CO_FILL, CO_FETCH_LOCK, CO_IDX_INV, CO_IDX_WB_INV,
      CO_IDX_LD_TAG, CO_IDX_ST_TAG, CO_IDX_LD_DATA, CO_IDX_ST_DATA,
      CO_HIT_INV, CO_HIT_WB_INV, CO_HIT_WB, CO_ICACHE_SYNC_OP
   } clw_op_t;

   typedef enum logic [1:0] {ST_INV, ST_SHR, ST_EXC, ST_MOD} clw_mesi_t;

   // way-order bit of a pair; one means the lower way is the newer
   function automatic logic [2:0] clw_pair(input int lo, input int hi);
      case ({2'(lo), 2'(hi)})
         4'h1: return 3'h2;
         4'h2: return 3'h5;
         4'h3: return 3'h3;
         4'h6: return 3'h1;
         4'h7: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   function automatic logic [5:0] clw_place(input logic [5:0] ord,
      input logic [1:0] w, input logic mru);
      logic [5:0] r;
      r = ord;
      for (int o = 0; o < WAYS; o++) begin
         if (o < int'(w)) r[clw_pair(o, int'(w))] = ~mru;
         else if (o > int'(w)) r[clw_pair(int'(w), o)] = mru;
      end
      return r;
   endfunction

   function automatic logic clw_newer(input logic [5:0] ord, input int a,
      input int b);
      if (a < b) return ord[clw_pair(a, b)];
      return ~ord[clw_pair(b, a)];
   endfunction

   function automatic logic [1:0] clw_lru(input logic [5:0] ord,
      input logic [3:0] m);
      logic [1:0] r;
      logic ok;
      r = 2'h0;
      for (int c = WAYS - 1; c >= 0; c--) begin
         ok = m[c];
         for (int d = 0; d < WAYS; d++) begin
            if (d != c && m[d] && !clw_newer(ord, d, c)) ok = 1'b0;
         end
         if (ok) r = 2'(c);
      end
      return r;
   endfunction
endpackage
